/* amp_defs.vh */
`ifndef AMP_DEFS_VH
`define AMP_DEFS_VH

// Register map
`define AMP_ADDR_EVFLAG 6'h3E
`define AMP_ADDR_EVMASK 6'h3F

// Field positions in the event flag register
`define AMP_BIT_PARERR 7

// Reset values
`define AMP_RST_EVFLAG 8'h00
`define AMP_RST_EVMASK 8'hFF

`endif

/* amp_host.sv */
`default_nettype none
module amp_host (
  input wire logic clock_in,
  input wire logic ack_n_in,
  input wire logic [8:0] bus_in,
  output logic sel_n_out,
  output logic rw_out,
  output logic [5:0] addr_out,
  output logic [8:0] dq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    sel_n_out = 1;
    rw_out = 1;
    addr_out = 0;
    dq_out = 0;
  end
  // One full cycle: select is released once acknowledge falls; rw and address stay put until acknowledge is released
  task automatic xfer(input logic r, input logic [5:0] a, input logic [8:0] d,
    output logic [8:0] q);
    @(posedge clock_in);
    #1;
    sel_n_out = 0;
    rw_out = r;
    addr_out = a;
    dq_out = d;
    do @(posedge clock_in); while (ack_n_in !== 1'b0);
    q = bus_in;
    #1;
    sel_n_out = 1;
    dq_out = ~dq_out;
    do @(posedge clock_in); while (ack_n_in !== 1'b1);
  endtask
endmodule
`default_nettype wire

/* amp_port.v */
// Function
// [R1] 64 registers of 8 bits, read and write
// [R2] Six-bit address picks one register
// [R3] Cycle starts only while select is low
// [R4] Host holds controls stable at select
// [R5] Read when rw high, write when low
// [R6] Acknowledge low marks cycle completion
// [R7] Read data and parity valid during acknowledge
// [R8] Host holds write data until acknowledge
// [R9] Acknowledge stays low while select low
// [R10] Interrupt low on unmasked recorded event
// [R11] Host reads event flags after interrupt
// [R12] Each event has a mask bit
// [R13] Highest address line is the MSB
// [R14] Odd parity over eight data lines
// [R15] Bad write parity blocks write, sets flag
// [R16] Select synchronised; release after select high
// [R17] One access per select low period
`include "amp_defs.vh"
`default_nettype none

module amp_port #(
  parameter ADDR_W = 6,
  parameter DATA_W = 8,
  parameter DEPTH = 64
) (
  // Clock and reset
  input wire clock_in,
  input wire arst_n_in,
  // Host control pins
  input wire host_sel_n_in,
  input wire host_rw_in,
  input wire [ADDR_W-1:0] host_addr_in,
  // Host data and parity pins, three signals each
  input wire [DATA_W-1:0] host_data_in,
  output reg [DATA_W-1:0] host_data_out,
  output reg host_data_oe_n_out,
  input wire host_parity_in,
  output reg host_parity_out,
  output reg host_parity_oe_n_out,
  // Open-drain acknowledge
  input wire host_ack_n_in,
  output reg host_ack_n_out,
  output reg host_ack_n_oe_n_out,
  // Open-drain interrupt
  input wire host_int_n_in,
  output reg host_int_n_out,
  output reg host_int_n_oe_n_out,
  // Core side: events and register write notification
  input wire [DATA_W-1:0] event_in,
  output reg reg_wr_strobe_out,
  output reg [ADDR_W-1:0] reg_wr_addr_out,
  output reg [DATA_W-1:0] reg_wr_data_out
);

  // Binary-coded port sequencer states
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_SETTLE = 2'h1;
  localparam [1:0] ST_ACCESS = 2'h2;
  localparam [1:0] ST_HOLD = 2'h3;

  function odd_par;
    input [DATA_W-1:0] d;
    begin
      odd_par = ~(^d);
    end
  endfunction

  // Address decode shared by the read path and the write path
  function is_flags;
    input [ADDR_W-1:0] a;
    begin
      is_flags = (a == `AMP_ADDR_EVFLAG);
    end
  endfunction

  function is_mask;
    input [ADDR_W-1:0] a;
    begin
      is_mask = (a == `AMP_ADDR_EVMASK);
    end
  endfunction

  function is_plain;
    input [ADDR_W-1:0] a;
    begin
      is_plain = !is_flags(a) && !is_mask(a);
    end
  endfunction

  // Pin inputs through two flops before any logic reads them
  wire sel_n_s;
  wire rw_s;
  wire [ADDR_W-1:0] addr_s;
  wire [DATA_W-1:0] data_s;
  wire par_s;

  amp_sync #(
    .WIDTH(3 + ADDR_W + DATA_W),
    .RST_VAL({1'b1, {(2 + ADDR_W + DATA_W){1'b0}}})
  ) u_sync (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .async_in({host_sel_n_in, host_rw_in, host_addr_in, host_data_in, host_parity_in}),
    .sync_out({sel_n_s, rw_s, addr_s, data_s, par_s})
  ); // [R16]

  reg [DATA_W-1:0] mem_r [0:DEPTH-1]; // [R1]
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [DATA_W-1:0] evflag_r;
  wire [DATA_W-1:0] evflag_nxt;
  reg [DATA_W-1:0] evmask_r;
  reg [DATA_W-1:0] evmask_nxt;
  wire [DATA_W-1:0] pend_nxt;
  reg [DATA_W-1:0] rd_val;
  reg par_ok;
  reg do_wr;
  reg do_rd;
  reg par_err_set;
  wire wr_flags;
  wire wr_mask;
  wire wr_plain;

  // Unused open-drain pin readbacks; the device never samples its own wires
  wire unused_pins;
  assign unused_pins = host_ack_n_in ^ host_int_n_in;

  assign wr_flags = do_wr && is_flags(addr_s);
  assign wr_mask = do_wr && is_mask(addr_s);
  assign wr_plain = do_wr && is_plain(addr_s);

  always @*
  begin
    if (is_flags(addr_s)) // [R13]
      rd_val = evflag_r;
    else if (is_mask(addr_s))
      rd_val = evmask_r;
    else
      rd_val = mem_r[addr_s]; // [R2]
  end

  always @*
  begin
    state_nxt = state_r;
    do_wr = 1'b0;
    do_rd = 1'b0;
    par_err_set = 1'b0;
    par_ok = (odd_par(data_s) == par_s); // [R14]
    case (state_r)
      ST_IDLE:
      begin
        if (!sel_n_s) // [R3]
          state_nxt = ST_SETTLE;
      end
      // One extra cycle absorbs skew between the separately synchronised pins
      ST_SETTLE:
      begin
        if (sel_n_s)
          state_nxt = ST_IDLE;
        else
          state_nxt = ST_ACCESS;
      end
      ST_ACCESS:
      begin
        state_nxt = ST_HOLD;
        if (rw_s) // [R5]
          do_rd = 1'b1;
        else if (par_ok)
          do_wr = 1'b1;
        else
          par_err_set = 1'b1; // [R15]
      end
      // A long select still gives one access; the sequencer waits here for release
      ST_HOLD:
      begin
        if (sel_n_s) // [R17]
          state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @*
  begin
    evmask_nxt = evmask_r;
    if (wr_mask)
      evmask_nxt = data_s; // [R12]
  end

  // Write one to clear; a new event in the same cycle still sets its bit
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi = gi + 1)
    begin : g_flag
      wire set_bit;
      wire clr_bit;
      assign set_bit = event_in[gi] | (par_err_set && gi == `AMP_BIT_PARERR); // [R15]
      assign clr_bit = wr_flags & data_s[gi];
      assign evflag_nxt[gi] = set_bit | (evflag_r[gi] & ~clr_bit);
    end
  endgenerate

  // Interrupt follows next-state values so it moves with the flag, not a cycle later
  assign pend_nxt = evflag_nxt & ~evmask_nxt; // [R12]

  always @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_r <= ST_IDLE;
      evflag_r <= `AMP_RST_EVFLAG;
      evmask_r <= `AMP_RST_EVMASK;
    end
    else
    begin
      state_r <= state_nxt;
      evflag_r <= evflag_nxt;
      evmask_r <= evmask_nxt;
    end
  end

  // Storage has no reset: contents are undefined until written
  always @(posedge clock_in)
  begin
    if (wr_plain)
      mem_r[addr_s] <= data_s; // [R1]
  end

  // Core side sees every accepted write, flag and mask registers included
  always @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      reg_wr_strobe_out <= 1'b0;
      reg_wr_addr_out <= {ADDR_W{1'b0}};
      reg_wr_data_out <= {DATA_W{1'b0}};
    end
    else
    begin
      reg_wr_strobe_out <= do_wr;
      if (do_wr)
      begin
        reg_wr_addr_out <= addr_s;
        reg_wr_data_out <= data_s;
      end
    end
  end

  // Read data is captured once per access and held, so it cannot move under acknowledge
  always @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      host_data_out <= {DATA_W{1'b0}};
      host_data_oe_n_out <= 1'b1;
      host_parity_out <= 1'b0;
      host_parity_oe_n_out <= 1'b1;
    end
    else if (do_rd)
    begin
      host_data_out <= rd_val; // [R7]
      host_parity_out <= odd_par(rd_val); // [R14]
      host_data_oe_n_out <= 1'b0;
      host_parity_oe_n_out <= 1'b0;
    end
    else if (state_nxt == ST_IDLE)
    begin
      host_data_oe_n_out <= 1'b1; // [R16]
      host_parity_oe_n_out <= 1'b1;
    end
  end

  // Acknowledge level is fixed low; only its enable moves
  always @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      host_ack_n_out <= 1'b0;
      host_ack_n_oe_n_out <= 1'b1;
    end
    else
    begin
      host_ack_n_out <= 1'b0;
      if (state_r == ST_ACCESS)
        host_ack_n_oe_n_out <= 1'b0; // [R6]
      else if (state_nxt == ST_IDLE)
        host_ack_n_oe_n_out <= 1'b1; // [R9]
    end
  end

  always @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      host_int_n_out <= 1'b0;
      host_int_n_oe_n_out <= 1'b1;
    end
    else
    begin
      host_int_n_out <= 1'b0;
      host_int_n_oe_n_out <= ~(|pend_nxt); // [R10]
    end
  end

endmodule

`default_nettype wire

/* amp_port_monitor.sv */
`default_nettype none
module amp_mon (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic host_sel_n_in,
  input wire logic host_rw_in,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe_n_out,
  input wire logic host_parity_out,
  input wire logic host_ack_n_oe_n_out,
  input wire logic reg_wr_strobe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  a_ack_late: assert property ($fell(host_sel_n_in) |-> ##[4:6] !host_ack_n_oe_n_out)
    else $error("ack late");
  a_ack_cause: assert property ($fell(host_ack_n_oe_n_out) |-> !$past(host_sel_n_in, 2))
    else $error("ack without select");
  a_ack_held: assert property (!host_ack_n_oe_n_out && !host_sel_n_in |=> !host_ack_n_oe_n_out)
    else $error("ack dropped");
  a_ack_release: assert property ($rose(host_sel_n_in) |-> ##[0:4] host_ack_n_oe_n_out)
    else $error("ack not released");
  a_read_drive: assert property (!host_ack_n_oe_n_out && host_rw_in |-> !host_data_oe_n_out)
    else $error("read data not driven");
  a_read_stable: assert property (!host_data_oe_n_out && $past(!host_data_oe_n_out)
    |-> $stable(host_data_out))
    else $error("read data moved");
  a_read_parity: assert property (!host_data_oe_n_out |-> host_parity_out == ~^host_data_out)
    else $error("bad read parity");
  a_write_once: assert property (reg_wr_strobe_out |=> !reg_wr_strobe_out [*6])
    else $error("double write");
  a_write_mode: assert property (reg_wr_strobe_out |-> !host_rw_in && host_data_oe_n_out)
    else $error("write in read mode");
  c_write: cover property (reg_wr_strobe_out);
  c_read: cover property ($fell(host_data_oe_n_out));
  c_release: cover property ($rose(host_ack_n_oe_n_out));
endmodule
bind amp_port amp_mon i_mon (.clock_in(clock_in), .arst_n_in(arst_n_in),
  .host_sel_n_in(host_sel_n_in), .host_rw_in(host_rw_in), .host_data_out(host_data_out),
  .host_data_oe_n_out(host_data_oe_n_out), .host_parity_out(host_parity_out),
  .host_ack_n_oe_n_out(host_ack_n_oe_n_out), .reg_wr_strobe_out(reg_wr_strobe_out));
`default_nettype wire

/* amp_sync.v */
`default_nettype none

module amp_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  // Clock and reset
  input wire clock_in,
  input wire arst_n_in,
  // Data
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  always @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end
    else
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

`default_nettype wire

/* async_mgmt_register_port_test.sv */
`default_nettype none
module async_mgmt_register_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 0, arst_n_in = 0, sel_n, rw, dat_oe_n, par_oe_n, ack_oe_n, ack_o;
  logic int_oe_n, int_o, stb, par_o;
  logic [5:0] addr, wa, la = 0;
  logic [7:0] ev = 0, dat_o, wd, ld = 0, m [64];
  logic [8:0] h_dq;
  logic [31:0] s = 84, r;
  int fail_count = 0, check_count = 0, cyc = 0, nstb = 0, nw = 0;
  wire [8:0] bus = {par_oe_n ? h_dq[8] : par_o, dat_oe_n ? h_dq[7:0] : dat_o};
  wire ack_w = ack_oe_n | ack_o;
  wire int_w = int_oe_n | int_o;
  amp_port i_amp_port (.clock_in(clock_in), .arst_n_in(arst_n_in), .host_sel_n_in(sel_n),
    .host_rw_in(rw), .host_addr_in(addr), .host_data_in(bus[7:0]), .host_data_out(dat_o),
    .host_data_oe_n_out(dat_oe_n), .host_parity_in(bus[8]), .host_parity_out(par_o),
    .host_parity_oe_n_out(par_oe_n), .host_ack_n_in(ack_w), .host_ack_n_out(ack_o),
    .host_ack_n_oe_n_out(ack_oe_n), .host_int_n_in(int_w), .host_int_n_out(int_o),
    .host_int_n_oe_n_out(int_oe_n), .event_in(ev), .reg_wr_strobe_out(stb),
    .reg_wr_addr_out(wa), .reg_wr_data_out(wd));
  amp_host i_host (.clock_in(clock_in), .ack_n_in(ack_w), .bus_in(bus), .sel_n_out(sel_n),
    .rw_out(rw), .addr_out(addr), .dq_out(h_dq));
  initial forever #5 clock_in = ~clock_in;
  always @(posedge clock_in)
  begin
    nstb += (stb === 1'b1);
    if (++cyc == 5000)
    begin
      fail_count++;
      tally_and_finish;
    end
  end
  function automatic logic [31:0] rnd;
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic op(input logic rd, input logic [5:0] a, input logic [7:0] d, input logic bad);
    logic [8:0] q;
    i_host.xfer(rd, a, {(~^d) ^ bad, d}, q);
    if (rd) chk(q, {~^m[a], m[a]});
    else if (bad) m[62][7] = 1;
    else if (a == 62) m[62] &= ~d;
    else m[a] = d;
    if (!rd && !bad) {la, ld} = {a, d};
    if (!rd) chk({wa, wd}, {la, ld});
    nw += !rd && !bad;
    chk(int_w, ~|(m[62] & ~m[63]));
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    m[62] = 8'h00;
    m[63] = 8'hFF;
    repeat (8) @(posedge clock_in);
    #1 arst_n_in = 1;
    op(1, 62, 0, 0);
    op(1, 63, 0, 0);
    for (int i = 0; i < 62; i++)
    begin
      r = rnd();
      op(0, i[5:0], r[7:0], 0);
    end
    for (int i = 0; i < 62; i++) op(1, i[5:0], 0, 0);
    $display("test done: storage");
    op(0, 5, 8'hA5, 1);
    op(1, 5, 0, 0);
    op(0, 63, 8'h7E, 0);
    @(posedge clock_in) #1 ev = 8'h01;
    @(posedge clock_in) #1 ev = 8'h00;
    m[62][0] = 1;
    op(1, 62, 0, 0);
    op(0, 62, 8'h81, 0);
    op(1, 62, 0, 0);
    chk(nstb[8:0], nw[8:0]);
    $display("test done: parity and events");
    tally_and_finish;
  end
endmodule
`default_nettype wire
